// File: hw/serdes_config_latch_bank.sv
`include "serdes_cfg_params.svh"
`default_nettype none
// Behaviour
// - Reclocker driver enables drive outputs, reset 0
// - Disabled drivers power down; both off idles reclocker
// - Device reset low disables every serial driver
// - Clock select resets 1; 1 bypasses align buffer
// - Rate select resets 0; multiplier 10 or 20
// - Reference source plus double rate: both edges
// - Self-test disable resets 1; 0 enables BIST
// - Transmit driver enables reset 0; both off powers down
// - Writing 0 to buffer reset recenters buffer only with clock select 0
// - Buffer reset sampled on transmit clock rising edges
// - Buffer reset latch clears itself when done
// - Decode eight 3-bit latch addresses, 7-bit data
// - Receive enable resets 0; 0 powers receiver down
module serdes_config_latch_bank (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic dev_reset_n,
  input wire logic tx_input_clock,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output serdes_cfg_pkg::rx_ctrl_t rx_ctrl,
  output serdes_cfg_pkg::tx_ctrl_t tx_ctrl,
  output logic phase_align_buf_reset
);
  // Maps a byte address to a latch index; 4'hf flags no register
  function automatic logic [3:0] addr_idx(input logic [31:0] a);
    if (a[1:0] != 2'h0 || a[31:6] != 26'h0) begin
      addr_idx = 4'hf;
    end else if (a[5:2] > `IDX_STATUS) begin
      addr_idx = 4'hf;
    end else begin
      addr_idx = a[5:2];
    end
  endfunction

  // True for indices that hold a configuration latch
  function automatic logic is_latch(input logic [3:0] i);
    is_latch = (i <= `IDX_TX_DYN) && (i != `IDX_RSVD_THREE) && (i != `IDX_RSVD_FOUR);
  endfunction

  // Reset image per index
  function automatic logic [6:0] rst_img(input logic [3:0] i);
    if (i == 4'h0 || i == 4'h5) begin
      rst_img = `RST_S0;
    end else if (i == 4'h1 || i == 4'h6) begin
      rst_img = `RST_S1;
    end else begin
      rst_img = `RST_DYN;
    end
  endfunction

  // Writable bits per index
  function automatic logic [6:0] wmask(input logic [3:0] i);
    if (i == `IDX_RX_CLK_RATE) begin
      wmask = `WMASK_0;
    end else if (i == `IDX_RX_DET_TRN) begin
      wmask = `WMASK_1;
    end else if (i == `IDX_RX_DYN) begin
      wmask = `WMASK_2;
    end else if (i == `IDX_TX_CLK) begin
      wmask = `WMASK_6;
    end else if (i == `IDX_TX_DYN) begin
      wmask = `WMASK_7;
    end else begin
      wmask = `WMASK_5;
    end
  endfunction

  // Pin synchronisers: device reset and transmit input clock
  logic [1:0] drst_sync_r; // Bit 0 feeds only bit 1
  logic [2:0] txck_sync_r; // Bit 2 is the previous synced level
  logic dev_run; // High while device reset is released
  logic txck_rise; // One cycle per transmit clock rising edge

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      drst_sync_r <= 2'h0;
      txck_sync_r <= 3'h0;
    end else begin
      drst_sync_r <= {drst_sync_r[0], dev_reset_n};
      txck_sync_r <= {txck_sync_r[1:0], tx_input_clock};
    end
  end

  assign dev_run = drst_sync_r[1];
  assign txck_rise = txck_sync_r[1] & ~txck_sync_r[2];

  // AXI write channel state
  serdes_cfg_pkg::wr_state_t wst_r;
  logic aw_have_r; // Address taken, waiting for data
  logic w_have_r; // Data taken, waiting for address
  logic [3:0] aw_idx_r;
  logic [6:0] w_data_r;
  logic w_lane0_r; // Low byte lane was strobed
  logic aw_fire;
  logic w_fire;
  logic wr_go; // One cycle: address and data each held or accepted this cycle
  logic [3:0] wr_idx;
  logic [6:0] wr_data;
  logic wr_lane0;

  assign s_axi_awready = (wst_r == serdes_cfg_pkg::W_IDLE) && !aw_have_r;
  assign s_axi_wready = (wst_r == serdes_cfg_pkg::W_IDLE) && !w_have_r;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire = s_axi_wvalid & s_axi_wready;
  assign wr_go = (aw_have_r | aw_fire) & (w_have_r | w_fire);
  assign wr_idx = aw_have_r ? aw_idx_r : addr_idx(s_axi_awaddr);
  assign wr_data = w_have_r ? w_data_r : s_axi_wdata[6:0];
  assign wr_lane0 = w_have_r ? w_lane0_r : s_axi_wstrb[0];

  // Address and data may arrive in either order
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wst_r <= serdes_cfg_pkg::W_IDLE;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_idx_r <= 4'h0;
      w_data_r <= 7'h00;
      w_lane0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      case (wst_r)
        serdes_cfg_pkg::W_IDLE: begin
          if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Reserved and unmapped addresses answer SLVERR
            s_axi_bresp <= is_latch(wr_idx) ? 2'h0 : 2'h2;
            wst_r <= serdes_cfg_pkg::W_RESP;
          end else begin
            if (aw_fire) begin
              aw_have_r <= 1'b1;
              aw_idx_r <= addr_idx(s_axi_awaddr);
            end
            if (w_fire) begin
              w_have_r <= 1'b1;
              w_data_r <= s_axi_wdata[6:0];
              w_lane0_r <= s_axi_wstrb[0];
            end
          end
        end
        serdes_cfg_pkg::W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wst_r <= serdes_cfg_pkg::W_IDLE;
          end
        end
        default: wst_r <= serdes_cfg_pkg::W_IDLE;
      endcase
    end
  end

  // Latch array; reserved slots stay at their reset image
  logic [6:0] lat_r [0:7];
  logic pab_clear; // Buffer reset request cleared this cycle, on a transmit clock edge or at once when bypassed

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_lat
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          lat_r[g] <= rst_img(4'(g));
        end else if (!dev_run) begin
          lat_r[g] <= rst_img(4'(g));
        end else if (wr_go && wst_r == serdes_cfg_pkg::W_IDLE && wr_lane0 &&
                     wr_idx == 4'(g) && is_latch(4'(g))) begin
          // Only mapped bits change; don't-care and constant bits hold
          lat_r[g] <= (lat_r[g] & ~wmask(4'(g))) | (wr_data & wmask(4'(g)));
        end else if (g == 7 && pab_clear) begin
          lat_r[g][`B_PAB] <= 1'b1;
        end
      end
    end
  endgenerate

  // Buffer reset is pending while its latch reads 0
  logic pab_pending;
  assign pab_pending = ~lat_r[7][`B_PAB];
  // A fresh 0 written in the clearing cycle wins: latch write precedes clear
  assign pab_clear = pab_pending & (txck_rise | tx_ctrl.tx_buf_bypass);

  // Buffer reset pulse toward the transmit clock domain logic
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_align_buf_reset <= 1'b0;
    end else begin
      phase_align_buf_reset <= pab_clear & ~tx_ctrl.tx_buf_bypass;
    end
  end

  // Receive side decode
  always_comb begin
    rx_ctrl.reclk_pri_drv_en = lat_r[2][`B_RECLK_PRI] & dev_run;
    rx_ctrl.reclk_sec_drv_en = lat_r[2][`B_RECLK_SEC] & dev_run;
    // Reclocker idles when neither driver is on
    rx_ctrl.reclk_powerdown = ~(rx_ctrl.reclk_pri_drv_en | rx_ctrl.reclk_sec_drv_en);
    rx_ctrl.rx_channel_enable = lat_r[2][`B_RX_EN];
    rx_ctrl.rx_pll_powerdown = ~lat_r[2][`B_RX_EN];
    rx_ctrl.rx_mode_field = {lat_r[2][`B_MODE_HI], lat_r[2][`B_MODE_LO]};
    rx_ctrl.rx_clock_rate_sel = lat_r[0][`B_RX_RATE];
    rx_ctrl.pri_detect_level_sel = lat_r[1][`B_PRI_DET +: 2];
    rx_ctrl.sec_detect_level_sel = lat_r[1][`B_SEC_DET +: 2];
    rx_ctrl.train_clock_rate_sel = lat_r[1][`B_TRN_RATE];
  end

  // Transmit side decode
  always_comb begin
    tx_ctrl.tx_pri_drv_en = lat_r[7][`B_TX_PRI] & dev_run;
    tx_ctrl.tx_sec_drv_en = lat_r[7][`B_TX_SEC] & dev_run;
    tx_ctrl.tx_chan_powerdown = ~(tx_ctrl.tx_pri_drv_en | tx_ctrl.tx_sec_drv_en);
    tx_ctrl.tx_clk_source_sel = lat_r[6][`B_TX_CKSEL];
    tx_ctrl.tx_buf_bypass = lat_r[6][`B_TX_CKSEL];
    tx_ctrl.tx_pll_rate_sel = lat_r[6][`B_TX_RATE];
    tx_ctrl.tx_pll_mult = lat_r[6][`B_TX_RATE] ? `MULT_DOUBLE : `MULT_FULL;
    // Reference clocking at double rate uses both edges
    tx_ctrl.tx_capture_both_edges = lat_r[6][`B_TX_CKSEL] & lat_r[6][`B_TX_RATE];
    tx_ctrl.tx_bist_enable = ~lat_r[7][`B_TX_BIST_DIS];
  end

  // Read channel; latches read back, status shows live state
  serdes_cfg_pkg::rd_state_t rst_r;
  logic [3:0] rd_idx;
  assign rd_idx = addr_idx(s_axi_araddr);
  assign s_axi_arready = (rst_r == serdes_cfg_pkg::R_IDLE);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_r <= serdes_cfg_pkg::R_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      case (rst_r)
        serdes_cfg_pkg::R_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            rst_r <= serdes_cfg_pkg::R_DATA;
            if (is_latch(rd_idx)) begin
              s_axi_rdata <= {25'h0, lat_r[rd_idx[2:0]]};
              s_axi_rresp <= 2'h0;
            end else if (rd_idx == `IDX_STATUS) begin
              s_axi_rdata <= {28'h0, ~dev_run, tx_ctrl.tx_chan_powerdown,
                              rx_ctrl.reclk_powerdown, pab_pending};
              s_axi_rresp <= 2'h0;
            end else begin
              s_axi_rdata <= 32'h0;
              s_axi_rresp <= 2'h2;
            end
          end
        end
        serdes_cfg_pkg::R_DATA: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rst_r <= serdes_cfg_pkg::R_IDLE;
          end
        end
        default: rst_r <= serdes_cfg_pkg::R_IDLE;
      endcase
    end
  end

  // Checks
  sequence s_pab_write;
    wr_go && wst_r == serdes_cfg_pkg::W_IDLE && wr_lane0 &&
      wr_idx == `IDX_TX_DYN && !wr_data[`B_PAB];
  endsequence
  sequence s_pab_done;
    pab_pending && txck_rise && !tx_ctrl.tx_buf_bypass;
  endsequence

  drv_reset_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !drst_sync_r[1] |-> !(tx_ctrl.tx_pri_drv_en | tx_ctrl.tx_sec_drv_en |
      rx_ctrl.reclk_pri_drv_en | rx_ctrl.reclk_sec_drv_en))
    else $error("driver enabled during device reset");
  latch_reset_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(dev_run) |=> lat_r[2] == `RST_DYN && lat_r[7] == `RST_DYN && lat_r[6] == `RST_S1)
    else $error("latches not reinitialised by device reset");
  reclk_power_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rx_ctrl.reclk_powerdown == !(lat_r[2][`B_RECLK_PRI] || lat_r[2][`B_RECLK_SEC]) || !dev_run)
    else $error("reclocker power state wrong");
  tx_mult_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_ctrl.tx_pll_mult == (tx_ctrl.tx_pll_rate_sel ? 5'h14 : 5'h0a))
    else $error("transmit multiplier wrong");
  both_edges_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_ctrl.tx_capture_both_edges == (tx_ctrl.tx_buf_bypass && tx_ctrl.tx_pll_rate_sel))
    else $error("dual edge capture wrong");
  tx_bist_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tx_ctrl.tx_bist_enable != lat_r[7][3])
    else $error("transmit self-test state wrong");
  pab_request_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_pab_write and dev_run |=> pab_pending)
    else $error("buffer reset request lost");
  pab_selfclr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_pab_done and !(wr_go && wr_lane0 && wr_idx == `IDX_TX_DYN && !wr_data[`B_PAB])
      |=> phase_align_buf_reset && !pab_pending ##1 !phase_align_buf_reset)
    else $error("buffer reset did not self clear");
  dontcare_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    dev_run |=> lat_r[5] == `RST_S0 && lat_r[3] == `RST_DYN)
    else $error("don't-care latch changed");
endmodule
`default_nettype wire

// File: hw/serdes_cfg_params.svh
`ifndef SERDES_CFG_PARAMS_SVH
`define SERDES_CFG_PARAMS_SVH
// Latch indices; byte address is four times the index
`define IDX_RX_CLK_RATE 4'h0
`define IDX_RX_DET_TRN 4'h1
`define IDX_RX_DYN 4'h2
`define IDX_RSVD_THREE 4'h3
`define IDX_RSVD_FOUR 4'h4
`define IDX_TX_STATIC0 4'h5
`define IDX_TX_CLK 4'h6
`define IDX_TX_DYN 4'h7
`define IDX_STATUS 4'h8
// Reset images of the latches
`define RST_S0 7'h5f
`define RST_S1 7'h56
`define RST_DYN 7'h59
// Bits that software may change; all others keep their reset image
`define WMASK_0 7'h01
`define WMASK_1 7'h79
`define WMASK_2 7'h76
`define WMASK_5 7'h00
`define WMASK_6 7'h03
`define WMASK_7 7'h0f
// Field positions
`define B_RX_RATE 0
`define B_TRN_RATE 0
`define B_PRI_DET 3
`define B_SEC_DET 5
`define B_RECLK_PRI 1
`define B_RECLK_SEC 2
`define B_MODE_LO 4
`define B_RX_EN 5
`define B_MODE_HI 6
`define B_TX_RATE 0
`define B_TX_CKSEL 1
`define B_PAB 0
`define B_TX_PRI 1
`define B_TX_SEC 2
`define B_TX_BIST_DIS 3
// PLL multipliers
`define MULT_FULL 5'h0a
`define MULT_DOUBLE 5'h14
`endif

// File: hw/serdes_cfg_pkg.sv
`default_nettype none
package serdes_cfg_pkg;
  // Receive side controls
  typedef struct packed {
    logic reclk_pri_drv_en;
    logic reclk_sec_drv_en;
    logic reclk_powerdown;
    logic rx_channel_enable;
    logic rx_pll_powerdown;
    logic [1:0] rx_mode_field;
    logic rx_clock_rate_sel;
    logic [1:0] pri_detect_level_sel;
    logic [1:0] sec_detect_level_sel;
    logic train_clock_rate_sel;
  } rx_ctrl_t;
  // Transmit side controls
  typedef struct packed {
    logic tx_pri_drv_en;
    logic tx_sec_drv_en;
    logic tx_chan_powerdown;
    logic tx_clk_source_sel;
    logic tx_buf_bypass;
    logic tx_pll_rate_sel;
    logic [4:0] tx_pll_mult;
    logic tx_capture_both_edges;
    logic tx_bist_enable;
  } tx_ctrl_t;
  // Bus state machines
  typedef enum logic [1:0] {W_IDLE = 2'b01, W_RESP = 2'b10} wr_state_t;
  typedef enum logic [1:0] {R_IDLE = 2'b01, R_DATA = 2'b10} rd_state_t;
endpackage
`default_nettype wire

// File: tb/tx_clk_src.sv
`default_nettype none
// Transmit input clock source; it stands low while not running
module tx_clk_src (
  input wire logic run,
  output var logic tx_input_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  // Slow on purpose: the block samples this clock as data
  initial begin
    tx_input_clock = 1'b0;
    forever begin
      #50;
      tx_input_clock = run ? ~tx_input_clock : 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tb/serdes_config_latch_bank_tb.sv
`default_nettype none
module serdes_config_latch_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, arst_n, dev_reset_n, run;
  wire logic tx_input_clock;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pab_pulse;
  logic [1:0] bresp, rresp;
  serdes_cfg_pkg::rx_ctrl_t rx;
  serdes_cfg_pkg::tx_ctrl_t tx;
  int error_cnt, checks, pulses;
  // Reset images repeat every five latches
  logic [6:0] rv [3] = '{7'h5f, 7'h56, 7'h59};
  // Receive dynamic: write, read back, driver and power fields
  logic [23:0] rxt [3] = '{24'h101915, 24'h363f69, 24'h424b46};
  // Clock latch: write, read back, clocking fields
  logic [27:0] txs [2] = '{28'h03571e9, 28'h0155068};
  // Transmit dynamic: write, read back after self clear, drivers
  logic [19:0] txd [2] = '{20'h0e5fc, 20'h02539};

  serdes_config_latch_bank i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .dev_reset_n(dev_reset_n),
    .tx_input_clock(tx_input_clock),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_ctrl(rx), .tx_ctrl(tx), .phase_align_buf_reset(pab_pulse)
  );

  tx_clk_src i_src (.run(run), .tx_input_clock(tx_input_clock));

  // Counts buffer reset pulses; each stands for one cycle
  always @(posedge sys_clk) begin
    if (pab_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // One comparison; mismatches are reported and counted
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge sys_clk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!dd && wready === 1'b1) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge sys_clk);
    bready <= 1'b0;
    chk(bresp, er);
    // One edge with bready low, so a following call never re-raises it in this step
    @(posedge sys_clk);
  endtask

  // Read and compare data and response
  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
    // One edge with rready low before the next request
    @(posedge sys_clk);
  endtask

  // Bounded wait for the buffer reset pulse
  task automatic wait_pab;
    int n;
    n = 0;
    while (pab_pulse !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < 300, 1);
  endtask

  // Verdict and end of run
  task automatic tally_and_finish;
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    dev_reset_n = 1'b1;
    run = 1'b0;
    awaddr = '0;
    wdata = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    error_cnt = 0;
    checks = 0;
    pulses = 0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Reset images, reserved places refused
    for (int i = 0; i < 8; i++) begin
      if (i == 3 || i == 4) begin
        rd(32'(i * 4), 32'h0, 2'h2);
      end else begin
        rd(32'(i * 4), 32'(rv[i % 5]), 2'h0);
      end
    end
    chk(32'(rx), 32'h05f4);
    chk(32'(tx), 32'h0728);
    wr(32'h0c, 32'h7f, 2'h2);
    rd(32'h08, 32'h59, 2'h0);
    wr(32'h14, 32'h7f, 2'h0);
    rd(32'h14, 32'h5f, 2'h0);
    // Status after reset: both channels idle, nothing pending
    rd(32'h20, 32'h6, 2'h0);
    wr(32'h20, 32'h0, 2'h2);
    // Receive static latches; upper data bits are ignored
    wr(32'h00, 32'hffffff80, 2'h0);
    rd(32'h00, 32'h5e, 2'h0);
    wr(32'h04, 32'h29, 2'h0);
    rd(32'h04, 32'h2f, 2'h0);
    chk(32'(rx[5:0]), 32'h0b);
    // Receive dynamic latch; mode kept at 01 or 10
    for (int k = 0; k < 3; k++) begin
      wr(32'h08, 32'(rxt[k][23:16]), 2'h0);
      rd(32'h08, 32'(rxt[k][15:8]), 2'h0);
      chk(32'(rx[12:6]), 32'(rxt[k][7:0]));
    end
    // Both edges only with clock select high; static before dynamic
    for (int k = 0; k < 2; k++) begin
      wr(32'h18, 32'(txs[k][27:20]), 2'h0);
      rd(32'h18, 32'(txs[k][19:12]), 2'h0);
      chk(32'(tx[9:1]), 32'(txs[k][11:0]));
    end
    run <= 1'b1;
    // Buffer reset last, clocked by the transmit input clock
    for (int k = 0; k < 2; k++) begin
      wr(32'h1c, 32'(txd[k][19:12]), 2'h0);
      chk(32'({tx[12:10], tx[0]}), 32'(txd[k][3:0]));
      wait_pab();
      repeat (2) @(posedge sys_clk);
      rd(32'h1c, 32'(txd[k][11:4]), 2'h0);
    end
    run <= 1'b0;
    chk(pulses, 2);
    // Device reset turns every driver off and reloads latches
    dev_reset_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(32'({rx[12:11], tx[12:11]}), 32'h0);
    // A write during device reset must leave no trace
    wr(32'h1c, 32'h06, 2'h0);
    dev_reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(32'h1c, 32'h59, 2'h0);
    // Bypassed buffer: the request clears at once
    wr(32'h1c, 32'h08, 2'h0);
    rd(32'h1c, 32'h59, 2'h0);
    chk(pulses, 2);
    tally_and_finish();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
